/* core/ltca_top.sv */
// status side of the lvds receive interface: test failure and capture, detect flags, alarms
// assumes all event inputs are single-cycle pulses synchronous to ref_clk_i
//
// Functional notes
// - bank-3 failure register: bit 12 strobe mismatch, bits 11-0 data lanes, write one clears
// - each of four banks has an eight-entry read-only capture memory of 13-bit words
// - stop-on-first-error keeps the whole failing frame, possibly several mismatches
// - captured frame stored in sample order, first sample at lowest entry
// - capture entry: bit 12 strobe, bits 11-0 data, bits 15-13 read zero
// - strobe-detected flags in sync status bits 7-4, cleared by writing one
// - all strobe-detected flags clear when strobe-alignment enable rises
// - sysref-detected in sync status bit 0, cleared by write one or enable rising
// - fifo alarms only evaluated on input data transitions, never on constant data
// - fifo almost-empty bits 7-4 and almost-full bits 3-0, one per bank
// - a bank fifo that is not enabled never raises a level alarm
// - clock-loss alarm bits 7-4 once half the edges in 8 periods are missing
// - strobe-position alarm bits 3-0 when a strobe arrives at an unexpected position
// - misplaced strobe realigns fifo input side unless strobe-realign lock is set
// - system alarm bit 2 when sysref realigns the trigger clock divider
// - system alarm bit 1 when alignment disabled and sysref arrives misaligned
// - system alarm bit 0 when sysref edge or lvds strobe realigns the clocks
// - fifo, clock-loss and strobe alarms clear singly on write one, zero leaves them
// - per-bank test-running indication high while the test is active on that bank
// - each unmasked alarm group drives the alarm output, masked groups do not
`timescale 1ns/10ps
`include "ltca_map.svh"

module ltca_top
	import ltca_pkg::*;
(
	input wire logic ref_clk_i,
	input wire logic nrst_i,
	// register port
	input wire logic [11:0] reg_addr_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [15:0] reg_wdata_i,
	output logic [15:0] reg_rdata_o,
	output logic reg_rvalid_o,
	// test configuration from the control registers
	input wire logic [3:0] test_enable_i,
	input wire logic continuous_test_mode_i,
	input wire logic strobe_realign_lock_i,
	input wire logic test_trigger_i,
	// per-bank lane samples, four banks packed 13 bits each
	input wire logic [3:0] frame_start_i,
	input wire logic [3:0] sample_valid_i,
	input wire logic [51:0] sample_word_i,
	input wire logic [51:0] expect_word_i,
	// detection events
	input wire logic [3:0] strobe_seen_i,
	input wire logic sysref_seen_i,
	input wire logic strobe_align_enable_i,
	input wire logic sysref_align_enable_i,
	// fifo level events
	input wire logic [3:0] fifo_enabled_i,
	input wire logic [3:0] data_transition_i,
	input wire logic [3:0] fifo_almost_empty_i,
	input wire logic [3:0] fifo_almost_full_i,
	// lane clock and strobe position
	input wire logic [3:0] bank_configured_i,
	input wire logic [3:0] lane_period_tick_i,
	input wire logic [3:0] lane_clock_edge_i,
	input wire logic [3:0] strobe_misplaced_i,
	// sysref alignment events
	input wire logic sysref_edge_i,
	input wire logic sysref_misaligned_i,
	input wire logic trigger_divider_slip_i,
	input wire logic [7:0] alarm_mask_i,
	// results
	output logic [3:0] test_running_flag_o,
	output logic [3:0] fifo_realign_o,
	output logic clocks_realign_o,
	output logic alarm_o
);

	logic rst_meta;
	logic rst_n;
	logic [12:0] bank3_mismatch_flags;
	logic [3:0] strobe_detected_flag;
	logic sysref_detected_flag;
	logic [3:0] fifo_almost_empty_alarm;
	logic [3:0] fifo_almost_full_alarm;
	logic [3:0] lane_clock_loss_alarm;
	logic [3:0] strobe_position_alarm;
	logic trigger_divider_realigned_alarm;
	logic sysref_misalignment_alarm;
	logic clocks_realigned_alarm;
	logic strobe_align_q;
	logic sysref_align_q;
	logic trigger_q;
	logic [3:0] clk_loss_set;
	logic [3:0] run_flags;
	logic [3:0] miss_done;
	logic [12:0] bank_miss [0:3];
	logic [12:0] cap_word [0:3];
	logic [2:0] rd_idx;
	logic wr_fail;
	logic wr_sync;
	logic wr_fifo;
	logic wr_lane;
	logic wr_sys;
	logic realign_now;
	logic [15:0] next_rdata;

	// set wins over clear so that an event landing on a clear is kept
	function automatic logic [12:0] ltca_w1c(input logic [12:0] cur, input logic [12:0] set,
			input logic [12:0] clr);
		ltca_w1c = (cur & ~clr) | set;
	endfunction : ltca_w1c

	// address decode for a read or write of the given offset
	function automatic logic ltca_hit(input logic [11:0] addr, input logic [11:0] ofs);
		ltca_hit = (addr == ofs);
	endfunction : ltca_hit

	// reset released through two flops; asserts at once, releases on the clock
	always_ff @(posedge ref_clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	assign wr_fail = reg_wr_i && ltca_hit(reg_addr_i, `LTCA_OFS_BANK3_FAIL);
	assign wr_sync = reg_wr_i && ltca_hit(reg_addr_i, `LTCA_OFS_SYNC);
	assign wr_fifo = reg_wr_i && ltca_hit(reg_addr_i, `LTCA_OFS_FIFO);
	assign wr_lane = reg_wr_i && ltca_hit(reg_addr_i, `LTCA_OFS_LANE);
	assign wr_sys = reg_wr_i && ltca_hit(reg_addr_i, `LTCA_OFS_SYS);
	assign rd_idx = reg_addr_i[3:1];

	// per-bank test engines with their capture memories
	genvar gb;
	generate
		for (gb = 0; gb < `LTCA_BANKS; gb = gb + 1) begin : g_bank
			ltca_capture_bank u_bank (
				.clk_i(ref_clk_i),
				.rst_n_i(rst_n),
				.enable_i(test_enable_i[gb]),
				.cont_i(continuous_test_mode_i),
				.trig_i(test_trigger_i),
				.frame_start_i(frame_start_i[gb]),
				.sample_valid_i(sample_valid_i[gb]),
				.sample_i(sample_word_i[gb*13 +: 13]),
				.expect_i(expect_word_i[gb*13 +: 13]),
				.rd_idx_i(rd_idx),
				.rd_word_o(cap_word[gb]),
				.running_o(run_flags[gb]),
				.frame_miss_o(bank_miss[gb]),
				.frame_done_o(miss_done[gb])
			);
		end
	endgenerate

	assign test_running_flag_o = run_flags;

	// edge history of the alignment enables and the test trigger
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			strobe_align_q <= 1'b0;
			sysref_align_q <= 1'b0;
			trigger_q <= 1'b0;
		end else begin
			strobe_align_q <= strobe_align_enable_i;
			sysref_align_q <= sysref_align_enable_i;
			trigger_q <= test_trigger_i;
		end
	end

	// bank-3 failure flags; a fresh trigger clears the previous result
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			bank3_mismatch_flags <= 13'h0000;
		end else begin
			bank3_mismatch_flags <= ltca_w1c(bank3_mismatch_flags,
				miss_done[3] ? bank_miss[3] : 13'h0000,
				(wr_fail ? reg_wdata_i[12:0] : 13'h0000)
				| {13{test_trigger_i && !trigger_q}});
		end
	end

	// synchronization detect flags, also cleared by a rising alignment enable
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			strobe_detected_flag <= 4'h0;
			sysref_detected_flag <= 1'b0;
		end else begin
			strobe_detected_flag <= 4'(ltca_w1c({9'h000, strobe_detected_flag},
				{9'h000, strobe_seen_i},
				{9'h000, (wr_sync ? reg_wdata_i[7:4] : 4'h0)
				| {4{strobe_align_enable_i && !strobe_align_q}}}));
			sysref_detected_flag <= (sysref_detected_flag
				&& !(wr_sync && reg_wdata_i[`LTCA_SYNC_SYSREF_BIT])
				&& !(sysref_align_enable_i && !sysref_align_q))
				|| sysref_seen_i;
		end
	end

	// fifo level alarms: only on a data transition and only for an enabled fifo
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fifo_almost_empty_alarm <= 4'h0;
			fifo_almost_full_alarm <= 4'h0;
		end else begin
			fifo_almost_empty_alarm <= 4'(ltca_w1c({9'h000, fifo_almost_empty_alarm},
				{9'h000, fifo_almost_empty_i & data_transition_i & fifo_enabled_i},
				{9'h000, wr_fifo ? reg_wdata_i[7:4] : 4'h0}));
			fifo_almost_full_alarm <= 4'(ltca_w1c({9'h000, fifo_almost_full_alarm},
				{9'h000, fifo_almost_full_i & data_transition_i & fifo_enabled_i},
				{9'h000, wr_fifo ? reg_wdata_i[3:0] : 4'h0}));
		end
	end

	// clock-loss watch: count missing edges over each window of lvds periods
	genvar gc;
	generate
		for (gc = 0; gc < `LTCA_BANKS; gc = gc + 1) begin : g_clk
			logic [3:0] slot_cnt;
			logic [3:0] miss_cnt;
			logic [3:0] miss_total;
			assign miss_total = miss_cnt + {3'h0, !lane_clock_edge_i[gc]};
			always_ff @(posedge ref_clk_i or negedge rst_n) begin
				if (!rst_n) begin
					slot_cnt <= 4'h0;
					miss_cnt <= 4'h0;
					clk_loss_set[gc] <= 1'b0;
				end else begin
					clk_loss_set[gc] <= 1'b0;
					if (!bank_configured_i[gc]) begin
						slot_cnt <= 4'h0;
						miss_cnt <= 4'h0;
					end else if (lane_period_tick_i[gc]) begin
						if (slot_cnt == `LTCA_CLK_WINDOW - 4'h1) begin
							slot_cnt <= 4'h0;
							miss_cnt <= 4'h0;
							clk_loss_set[gc] <= (miss_total >= `LTCA_CLK_MISS_TRIP);
						end else begin
							slot_cnt <= slot_cnt + 4'h1;
							miss_cnt <= miss_total;
						end
					end
				end
			end
		end
	endgenerate

	// lane clock-loss and strobe-position alarms
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			lane_clock_loss_alarm <= 4'h0;
			strobe_position_alarm <= 4'h0;
		end else begin
			lane_clock_loss_alarm <= 4'(ltca_w1c({9'h000, lane_clock_loss_alarm},
				{9'h000, clk_loss_set},
				{9'h000, wr_lane ? reg_wdata_i[7:4] : 4'h0}));
			strobe_position_alarm <= 4'(ltca_w1c({9'h000, strobe_position_alarm},
				{9'h000, strobe_misplaced_i},
				{9'h000, wr_lane ? reg_wdata_i[3:0] : 4'h0}));
		end
	end

	// a misplaced strobe realigns the fifo input unless the realign lock is on
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			fifo_realign_o <= 4'h0;
		end else begin
			fifo_realign_o <= strobe_misplaced_i & {4{!strobe_realign_lock_i}};
		end
	end

	// clocks realign on an enabled sysref edge at the wrong phase, or on a strobe realign
	assign realign_now = (sysref_edge_i && sysref_align_enable_i && sysref_misaligned_i)
		|| ((strobe_misplaced_i & {4{!strobe_realign_lock_i}}) != 4'h0);

	// system alignment alarms
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			trigger_divider_realigned_alarm <= 1'b0;
			sysref_misalignment_alarm <= 1'b0;
			clocks_realigned_alarm <= 1'b0;
			clocks_realign_o <= 1'b0;
		end else begin
			clocks_realign_o <= realign_now;
			trigger_divider_realigned_alarm <= (trigger_divider_realigned_alarm
				&& !(wr_sys && reg_wdata_i[`LTCA_SYS_TRIG_BIT]))
				|| (sysref_edge_i && trigger_divider_slip_i);
			sysref_misalignment_alarm <= (sysref_misalignment_alarm
				&& !(wr_sys && reg_wdata_i[`LTCA_SYS_MISALIGN_BIT]))
				|| (sysref_edge_i && sysref_misaligned_i && !sysref_align_enable_i);
			clocks_realigned_alarm <= (clocks_realigned_alarm
				&& !(wr_sys && reg_wdata_i[`LTCA_SYS_REALIGN_BIT]))
				|| realign_now;
		end
	end

	// combined alarm output; each group is gated by its own mask bit
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			alarm_o <= 1'b0;
		end else begin
			alarm_o <= ((fifo_almost_empty_alarm | fifo_almost_full_alarm) != 4'h0
					&& !alarm_mask_i[`LTCA_MASK_FIFO_BIT])
				|| (lane_clock_loss_alarm != 4'h0 && !alarm_mask_i[`LTCA_MASK_CLK_BIT])
				|| (strobe_position_alarm != 4'h0 && !alarm_mask_i[`LTCA_MASK_STROBE_BIT])
				|| (trigger_divider_realigned_alarm && !alarm_mask_i[`LTCA_MASK_TRIG_BIT])
				|| (sysref_misalignment_alarm && !alarm_mask_i[`LTCA_MASK_MISALIGN_BIT])
				|| (clocks_realigned_alarm && !alarm_mask_i[`LTCA_MASK_REALIGN_BIT]);
		end
	end

	// read mux; capture words are 16-bit entries at even offsets, unmapped reads give zero
	always_comb begin
		next_rdata = `LTCA_RST_WORD;
		case (reg_addr_i[11:4])
			8'h76: next_rdata = {3'h0, cap_word[0]};
			8'h77: next_rdata = {3'h0, cap_word[1]};
			8'h78: next_rdata = {3'h0, cap_word[2]};
			8'h79: next_rdata = {3'h0, cap_word[3]};
			default: next_rdata = `LTCA_RST_WORD;
		endcase
		if (reg_addr_i[0]) next_rdata = `LTCA_RST_WORD;
		if (ltca_hit(reg_addr_i, `LTCA_OFS_BANK3_FAIL)) begin
			next_rdata = {3'h0, bank3_mismatch_flags};
		end
		if (ltca_hit(reg_addr_i, `LTCA_OFS_SYNC)) begin
			next_rdata = {8'h00, strobe_detected_flag, 3'h0, sysref_detected_flag};
		end
		if (ltca_hit(reg_addr_i, `LTCA_OFS_FIFO)) begin
			next_rdata = {8'h00, fifo_almost_empty_alarm, fifo_almost_full_alarm};
		end
		if (ltca_hit(reg_addr_i, `LTCA_OFS_LANE)) begin
			next_rdata = {8'h00, lane_clock_loss_alarm, strobe_position_alarm};
		end
		if (ltca_hit(reg_addr_i, `LTCA_OFS_SYS)) begin
			next_rdata = {8'h00, 5'h00, trigger_divider_realigned_alarm,
				sysref_misalignment_alarm, clocks_realigned_alarm};
		end
	end

	// read data registered one cycle after the strobe; reading during a run is not blocked
	always_ff @(posedge ref_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			reg_rdata_o <= `LTCA_RST_WORD;
			reg_rvalid_o <= 1'b0;
		end else begin
			reg_rvalid_o <= reg_rd_i;
			if (reg_rd_i) begin
				reg_rdata_o <= next_rdata; // caller must read only when not running
			end
		end
	end

endmodule : ltca_top

/* core/ltca_map.svh */
// register offsets, field positions, reset values and counts for the lvds test capture block
// assumes byte addressing on the register port, 16-bit data words
`ifndef LTCA_MAP_SVH
`define LTCA_MAP_SVH

`define LTCA_ADDR_W 12
`define LTCA_DATA_W 16
`define LTCA_WORD_W 13
`define LTCA_BANKS 4
`define LTCA_CAP_DEPTH 8

// register byte offsets
`define LTCA_OFS_BANK3_FAIL 12'h756
`define LTCA_OFS_CAP0 12'h760
`define LTCA_OFS_CAP1 12'h770
`define LTCA_OFS_CAP2 12'h780
`define LTCA_OFS_CAP3 12'h790
`define LTCA_OFS_SYNC 12'h800
`define LTCA_OFS_FIFO 12'h820
`define LTCA_OFS_LANE 12'h821
`define LTCA_OFS_SYS 12'h822

// field positions
`define LTCA_FAIL_STROBE_BIT 12
`define LTCA_SYNC_STROBE_LSB 4
`define LTCA_SYNC_SYSREF_BIT 0
`define LTCA_FIFO_EMPTY_LSB 4
`define LTCA_FIFO_FULL_LSB 0
`define LTCA_LANE_CLK_LSB 4
`define LTCA_LANE_STROBE_LSB 0
`define LTCA_SYS_TRIG_BIT 2
`define LTCA_SYS_MISALIGN_BIT 1
`define LTCA_SYS_REALIGN_BIT 0

// alarm mask bit positions
`define LTCA_MASK_FIFO_BIT 7
`define LTCA_MASK_CLK_BIT 6
`define LTCA_MASK_STROBE_BIT 5
`define LTCA_MASK_TRIG_BIT 2
`define LTCA_MASK_MISALIGN_BIT 1
`define LTCA_MASK_REALIGN_BIT 0

// reset values
`define LTCA_RST_BYTE 8'h00
`define LTCA_RST_WORD 16'h0000

// clock-loss window: lvds periods observed and misses that trip the alarm
`define LTCA_CLK_WINDOW 4'h8
`define LTCA_CLK_MISS_TRIP 4'h4

`endif

/* core/ltca_pkg.sv */
// types shared by the lvds test capture block
// assumes ltca_map.svh is available on the include path
package ltca_pkg;

	// capture unit state per bank
	typedef enum logic [1:0] {
		LTCA_IDLE = 2'b00,
		LTCA_ARMED = 2'b01,
		LTCA_RUN = 2'b10,
		LTCA_HOLD = 2'b11
	} ltca_state_t;

	typedef logic [12:0] ltca_word_t;

endpackage : ltca_pkg

/* core/ltca_capture_bank.sv */
// one bank's interface-test engine: frame compare, 8-word capture memory, run flag
// assumes sample, expected word and frame start arrive synchronous to ref_clk_i
`timescale 1ns/10ps
`include "ltca_map.svh"

module ltca_capture_bank
	import ltca_pkg::*;
(
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic enable_i,
	input wire logic cont_i,
	input wire logic trig_i,
	input wire logic frame_start_i,
	input wire logic sample_valid_i,
	input wire ltca_word_t sample_i,
	input wire ltca_word_t expect_i,
	input wire logic [2:0] rd_idx_i,
	output ltca_word_t rd_word_o,
	output logic running_o,
	output ltca_word_t frame_miss_o,
	output logic frame_done_o
);

	ltca_state_t state;
	ltca_state_t next_state;
	ltca_word_t cap_mem [0:`LTCA_CAP_DEPTH-1];
	ltca_word_t acc_miss;
	logic [2:0] idx;
	logic [2:0] cur_idx;
	logic last_sample;
	logic take;

	// frame start always marks sample 0
	assign cur_idx = frame_start_i ? 3'h0 : idx;
	assign take = sample_valid_i && ((state == LTCA_RUN)
		|| (state == LTCA_ARMED && frame_start_i));
	assign last_sample = take && (cur_idx == 3'h7);
	assign rd_word_o = cap_mem[rd_idx_i];

	// sample index within the frame
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			idx <= 3'h0;
		end else if (sample_valid_i) begin
			idx <= cur_idx + 3'h1;
		end
	end

	// capture in sample order, first sample at entry 0; no write outside run keeps the frame
	always_ff @(posedge clk_i) begin
		if (take) begin
			cap_mem[cur_idx] <= sample_i;
		end
	end

	// mismatch accumulated across one frame, reported at its last sample
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			acc_miss <= 13'h0000;
			frame_miss_o <= 13'h0000;
			frame_done_o <= 1'b0;
		end else begin
			frame_done_o <= last_sample;
			if (take) begin
				acc_miss <= (frame_start_i ? 13'h0000 : acc_miss) | (sample_i ^ expect_i);
			end
			if (last_sample) begin
				frame_miss_o <= acc_miss | (sample_i ^ expect_i);
			end
		end
	end

	// run control: arm on trigger, start on a frame boundary, hold the failing frame
	always_comb begin
		next_state = state;
		case (state)
			LTCA_IDLE: begin
				if (trig_i && enable_i) next_state = LTCA_ARMED;
			end
			LTCA_ARMED: begin
				if (!trig_i || !enable_i) next_state = LTCA_IDLE;
				else if (frame_start_i && sample_valid_i) next_state = LTCA_RUN;
			end
			LTCA_RUN: begin
				if (!trig_i || !enable_i) begin
					next_state = LTCA_IDLE;
				end else if (last_sample && !cont_i && ((acc_miss | (sample_i ^ expect_i)) != 13'h0000)) begin
					next_state = LTCA_HOLD;
				end
			end
			LTCA_HOLD: begin
				if (!trig_i) next_state = LTCA_IDLE;
			end
			default: next_state = LTCA_IDLE;
		endcase
	end

	// state register; running follows the state the test is entering
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= LTCA_IDLE;
			running_o <= 1'b0;
		end else begin
			state <= next_state;
			running_o <= (next_state == LTCA_RUN) || (next_state == LTCA_ARMED);
		end
	end

endmodule : ltca_capture_bank

/* testbench/ltca_top_props.sv */
// checker for ltca_top: read handshake, run flag, realign pulses and alarm output timing
// assumes it is bound to ltca_top and sees only that module's ports
`timescale 1ns/10ps
module ltca_top_props (
	input logic ref_clk_i,
	input logic nrst_i,
	input logic reg_rd_i,
	input logic reg_rvalid_o,
	input logic test_trigger_i,
	input logic [3:0] test_enable_i,
	input logic [3:0] test_running_flag_o,
	input logic strobe_realign_lock_i,
	input logic [3:0] strobe_misplaced_i,
	input logic [3:0] fifo_realign_o,
	input logic sysref_edge_i,
	input logic sysref_misaligned_i,
	input logic sysref_align_enable_i,
	input logic trigger_divider_slip_i,
	input logic [7:0] alarm_mask_i,
	input logic clocks_realign_o,
	input logic alarm_o
);
	// one clock domain, so clocking and reset are stated once
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!nrst_i);

	property p_rd_answer;
		reg_rd_i |=> reg_rvalid_o;
	endproperty
	a_rd_answer: assert property (p_rd_answer) else $error("read not answered");
	property p_rd_quiet;
		!reg_rd_i |=> !reg_rvalid_o;
	endproperty
	a_rd_quiet: assert property (p_rd_quiet) else $error("stray read valid");
	property p_run_start;
		$rose(test_trigger_i) && test_enable_i[0] |=> test_running_flag_o[0];
	endproperty
	a_run_start: assert property (p_run_start) else $error("run flag not raised");
	property p_run_stop;
		!test_trigger_i [*2] |-> test_running_flag_o == 4'h0;
	endproperty
	a_run_stop: assert property (p_run_stop) else $error("run flag stuck high");
	property p_fifo_realign;
		strobe_misplaced_i[0] && !strobe_realign_lock_i |=> fifo_realign_o[0];
	endproperty
	a_fifo_realign: assert property (p_fifo_realign) else $error("no fifo realign");
	property p_fifo_lock;
		strobe_realign_lock_i |=> fifo_realign_o == 4'h0;
	endproperty
	a_fifo_lock: assert property (p_fifo_lock) else $error("realign despite lock");
	property p_clk_realign;
		sysref_edge_i && sysref_align_enable_i && sysref_misaligned_i |=> clocks_realign_o;
	endproperty
	a_clk_realign: assert property (p_clk_realign) else $error("no clock realign");
	property p_clk_quiet;
		!sysref_edge_i && strobe_misplaced_i == 4'h0 |=> !clocks_realign_o;
	endproperty
	a_clk_quiet: assert property (p_clk_quiet) else $error("stray clock realign");
	property p_alarm_masked;
		(alarm_mask_i == 8'hE7) [*2] |-> !alarm_o;
	endproperty
	a_alarm_masked: assert property (p_alarm_masked) else $error("masked alarm shown");
	property p_alarm_trig;
		sysref_edge_i && trigger_divider_slip_i ##1 !alarm_mask_i[2] |=> alarm_o;
	endproperty
	a_alarm_trig: assert property (p_alarm_trig) else $error("trigger alarm not shown");
endmodule : ltca_top_props

bind ltca_top ltca_top_props u_props (
	.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .reg_rd_i(reg_rd_i), .reg_rvalid_o(reg_rvalid_o),
	.test_trigger_i(test_trigger_i), .test_enable_i(test_enable_i),
	.test_running_flag_o(test_running_flag_o), .strobe_realign_lock_i(strobe_realign_lock_i),
	.strobe_misplaced_i(strobe_misplaced_i), .fifo_realign_o(fifo_realign_o),
	.sysref_edge_i(sysref_edge_i), .sysref_misaligned_i(sysref_misaligned_i),
	.sysref_align_enable_i(sysref_align_enable_i), .trigger_divider_slip_i(trigger_divider_slip_i),
	.alarm_mask_i(alarm_mask_i), .clocks_realign_o(clocks_realign_o), .alarm_o(alarm_o)
);

/* testbench/ltca_fpga_model.sv */
// far-side lane source: one 8-sample test frame to every bank on request, fast or with gaps
// assumes go_i is raised by the bench for one cycle; outputs change on the falling edge
`timescale 1ns/10ps
module ltca_fpga_model (
	input wire logic clk_i,
	input wire logic go_i,
	input wire logic slow_i,
	input wire logic [12:0] err_i,
	output logic busy_o,
	output logic [3:0] frame_start_o,
	output logic [3:0] sample_valid_o,
	output logic [51:0] sample_word_o,
	output logic [51:0] expect_word_o
);
	logic [12:0] w;
	initial begin
		{busy_o, frame_start_o, sample_valid_o} = '0;
		{sample_word_o, expect_word_o} = '0;
	end
	// gap cycles and a fast release show the inverted word; a slow release inverts it back to the last word
	always begin
		@(posedge clk_i);
		if (go_i) begin
			for (int i = 0; i < 8; i++) begin
				@(negedge clk_i);
				busy_o = 1'b1;
				w = {i == 0, 12'hA50 + 12'(i)};
				expect_word_o = {4{w}};
				if (i == 3) w = w ^ err_i;
				if (i == 5) w = w ^ (err_i >> 1);
				sample_word_o = {4{w}};
				frame_start_o = {4{i == 0}};
				sample_valid_o = 4'hF;
				if (slow_i) begin
					@(negedge clk_i);
					{frame_start_o, sample_valid_o} = '0;
					sample_word_o = ~sample_word_o;
				end
			end
			@(negedge clk_i);
			{busy_o, frame_start_o, sample_valid_o} = '0;
			sample_word_o = ~sample_word_o;
		end
	end
endmodule : ltca_fpga_model

/* testbench/ltca_top_tb.sv */
// self-checking bench for ltca_top: register reads and clears, test capture, flags, alarms
// assumes ltca_fpga_model feeds the lanes and the checker is bound to the design
`timescale 1ns/10ps
`define CHK(nm, e, a) begin cmp_count++; if ((a) !== (e)) begin err_total++; \
	$display("[FAIL] %s expected %h seen %h", nm, e, a); end end
module ltca_top_tb;
	logic ref_clk_i = 0, nrst_i = 0, reg_wr_i = 0, reg_rd_i = 0, test_trigger_i = 0;
	logic continuous_test_mode_i = 0, strobe_realign_lock_i = 0, sysref_seen_i = 0;
	logic strobe_align_enable_i = 0, sysref_align_enable_i = 0, sysref_edge_i = 0;
	logic sysref_misaligned_i = 0, trigger_divider_slip_i = 0, go = 0, slow = 0, busy;
	logic [11:0] reg_addr_i = '0;
	logic [15:0] reg_wdata_i = '0, reg_rdata_o;
	logic [3:0] test_enable_i = '0, strobe_seen_i = '0, fifo_enabled_i = '0;
	logic [3:0] data_transition_i = '0, fifo_almost_empty_i = '0, fifo_almost_full_i = '0;
	logic [3:0] bank_configured_i = '0, lane_period_tick_i = '0, lane_clock_edge_i = '0;
	logic [3:0] strobe_misplaced_i = '0, frame_start_i, sample_valid_i;
	logic [3:0] test_running_flag_o, fifo_realign_o;
	logic [7:0] alarm_mask_i = '0;
	logic [12:0] err = '0;
	logic [51:0] sample_word_i, expect_word_i;
	logic reg_rvalid_o, clocks_realign_o, alarm_o;
	int err_total = 0, cmp_count = 0, cycles = 0;

	ltca_top DUT (.*);
	ltca_fpga_model u_fpga (.clk_i(ref_clk_i), .go_i(go), .slow_i(slow), .err_i(err),
		.busy_o(busy), .frame_start_o(frame_start_i), .sample_valid_o(sample_valid_i),
		.sample_word_o(sample_word_i), .expect_word_o(expect_word_i));

	always #2 ref_clk_i = ~ref_clk_i;

	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk_i);
	endtask : tick
	// strobes drop with a spare cycle so back-to-back calls never retoggle in one step
	task automatic reg_write(input logic [11:0] a, input logic [15:0] d);
		reg_addr_i = a;
		reg_wdata_i = d;
		reg_wr_i = 1'b1;
		tick(1);
		reg_wr_i = 1'b0;
		tick(1);
	endtask : reg_write
	task automatic reg_check(input logic [11:0] a, input logic [15:0] e);
		reg_addr_i = a;
		reg_rd_i = 1'b1;
		tick(1);
		reg_rd_i = 1'b0;
		`CHK("rvalid", 1'b1, reg_rvalid_o)
		`CHK($sformatf("reg %h", a), e, reg_rdata_o)
		tick(1);
	endtask : reg_check
	// expected capture entry i of the frame that the lane model sends with error mask e
	function automatic logic [15:0] cap_word(input int i, input logic [12:0] e);
		logic [12:0] w;
		w = {i == 0, 12'hA50 + 12'(i)};
		if (i == 3) w = w ^ e;
		if (i == 5) w = w ^ (e >> 1);
		return {3'b000, w};
	endfunction : cap_word
	task automatic give_verdict();
		if (err_total == 0 && cmp_count > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : give_verdict

	// a hang counts as a mismatch and still reaches the verdict
	always @(posedge ref_clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 4000) begin
			err_total++;
			give_verdict();
		end
	end

	logic [11:0] rst_tab [7] = '{12'h756, 12'h800, 12'h820, 12'h821, 12'h822, 12'h900, 12'h761};
	initial begin
		tick(4);
		nrst_i = 1'b1;
		tick(3);
		foreach (rst_tab[k]) reg_check(rst_tab[k], 16'h0000);
		// stop-on-first-error run with a slow source and two failing samples
		test_enable_i = 4'hF;
		test_trigger_i = 1'b1;
		tick(2);
		`CHK("running", 4'hF, test_running_flag_o)
		{slow, err, go} = {1'b1, 13'h1001, 1'b1};
		tick(1);
		go = 1'b0;
		tick(1);
		for (int k = 0; k < 40 && busy !== 1'b0; k++) tick(1);
		tick(3);
		`CHK("running", 4'h0, test_running_flag_o)
		reg_check(12'h756, 16'h1801);
		for (int b = 0; b < 4; b++)
			for (int i = 0; i < 8; i++)
				reg_check(12'h760 + 12'(16 * b + 2 * i), cap_word(i, 13'h1001));
		reg_write(12'h756, 16'h0800);
		reg_check(12'h756, 16'h1001);
		test_trigger_i = 1'b0;
		tick(2);
		test_trigger_i = 1'b1;
		tick(3);
		reg_check(12'h756, 16'h0000);
		test_trigger_i = 1'b0;
		// detection flags: set, clear by one, clear on enable rising, set beats clear
		strobe_seen_i = 4'h5;
		sysref_seen_i = 1'b1;
		tick(1);
		{strobe_seen_i, sysref_seen_i} = '0;
		tick(1);
		reg_check(12'h800, 16'h0051);
		reg_write(12'h800, 16'h0010);
		reg_check(12'h800, 16'h0041);
		strobe_align_enable_i = 1'b1;
		tick(2);
		reg_check(12'h800, 16'h0001);
		{reg_addr_i, reg_wdata_i, reg_wr_i, sysref_seen_i} = {12'h800, 16'h0001, 2'b11};
		tick(1);
		{reg_wr_i, sysref_seen_i} = 2'b00;
		tick(1);
		reg_check(12'h800, 16'h0001);
		sysref_align_enable_i = 1'b1;
		tick(2);
		reg_check(12'h800, 16'h0000);
		// fifo levels only count on data transitions and on enabled banks
		{fifo_enabled_i, fifo_almost_empty_i, fifo_almost_full_i} = {4'h3, 4'hF, 4'hF};
		tick(3);
		reg_check(12'h820, 16'h0000);
		data_transition_i = 4'hF;
		tick(1);
		data_transition_i = 4'h0;
		tick(1);
		reg_check(12'h820, 16'h0033);
		reg_write(12'h820, 16'h0001);
		reg_check(12'h820, 16'h0032);
		// bank 0 clock misses exactly half its edges; strobes misplaced with and without lock
		bank_configured_i = 4'h1;
		for (int i = 0; i < 8; i++) begin
			lane_period_tick_i = 4'h1;
			lane_clock_edge_i = {3'b000, i[0]};
			tick(1);
			lane_period_tick_i = 4'h0;
			tick(1);
		end
		tick(2);
		{strobe_realign_lock_i, strobe_misplaced_i} = {1'b1, 4'h2};
		tick(1);
		{strobe_realign_lock_i, strobe_misplaced_i} = {1'b0, 4'h1};
		tick(1);
		strobe_misplaced_i = 4'h0;
		tick(1);
		reg_check(12'h821, 16'h0013);
		reg_write(12'h821, 16'h0002);
		reg_check(12'h821, 16'h0011);
		// system alarms; the off-period sysref slips the trigger divider on purpose
		reg_write(12'h822, 16'h0007);
		reg_check(12'h822, 16'h0000);
		sysref_align_enable_i = 1'b0;
		tick(1);
		{sysref_edge_i, sysref_misaligned_i, trigger_divider_slip_i} = 3'b111;
		tick(1);
		{sysref_edge_i, trigger_divider_slip_i} = 2'b00;
		sysref_align_enable_i = 1'b1;
		tick(1);
		sysref_edge_i = 1'b1;
		tick(1);
		{sysref_edge_i, sysref_misaligned_i} = 2'b00;
		tick(2);
		reg_check(12'h822, 16'h0007);
		`CHK("alarm", 1'b1, alarm_o)
		alarm_mask_i = 8'hE7;
		tick(3);
		`CHK("alarm", 1'b0, alarm_o)
		give_verdict();
	end
endmodule : ltca_top_tb
